// ---- rtl/spi_buf_pkg.sv ----
// Constants and types for the serial status and data buffer block.
// Assumes a byte-wide register view placed on word-aligned Avalon-MM addresses.
// How it works
// - Set receive-complete when data reaches data register
// - Transmit-empty high exactly while transmit buffer empty
// - Set mode-fault on select low as master
// - Mode-fault cleared by status read, control-one write
// - Status readable anytime; writes change nothing
// - 8-bit: status read then low read clears
// - 16-bit: high reads harmless; low-only drops high
// - Transmit-empty cleared by armed low-byte write only
// - Data writes ignored while transmit-empty clear
// - Low-only write leaves high transmit byte undefined
// - Data high/low bytes at 4 and 5, reset zero
// - Master starts queued data right after previous
// - Completed reception with flag clear copies, sets flag
// - Second value waits in pendData, data unchanged
// - Serviced before third start: move, flag set again one cycle after the clear
// - Serviced after third start: waiting data discarded
// - Mode fault with interrupt enable requests interrupt
// - Mode fault forces slave, outputs off, abort
package spi_buf_pkg;
  localparam logic [2:0] CTRL_ONE_OFS = 3'h0;
  localparam logic [2:0] CTRL_TWO_OFS = 3'h1;
  localparam logic [2:0] STATUS_OFS = 3'h3;
  localparam logic [2:0] DATA_HIGH_OFS = 3'h4;
  localparam logic [2:0] DATA_LOW_OFS = 3'h5;
  localparam int RX_FLAG_BIT = 7;
  localparam int TX_EMPTY_BIT = 5;
  localparam int FAULT_BIT = 4;
  localparam int IRQ_EN_BIT = 7;
  localparam int MASTER_BIT = 4;
  localparam int WIDTH_BIT = 6;
  localparam int FAULT_EN_BIT = 4;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam int DIV_DEFAULT = 4;
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    SHIFT = 2'b01
  } xfer_state_t;
endpackage

// ---- rtl/shift_if.sv ----
// Link between register side and shift engine.
// Assumes one clock shared by both modules.
interface shift_if;
  logic start;
  logic abort;
  logic wide;
  logic [15:0] txWord;
  logic busy;
  logic started;
  logic done;
  logic [15:0] rxWord;
  modport ctrl (output start, abort, wide, txWord, input busy, started, done, rxWord);
  modport eng (input start, abort, wide, txWord, output busy, started, done, rxWord);
endinterface

// ---- rtl/spi_shift_engine.sv ----
// Master shift engine: clocks out 8 or 16 bits, msb first, mode 0.
// Assumes misoSync is already synchronised to core_clk.
module spi_shift_engine
  import spi_buf_pkg::*;
#(
  parameter int DIV = DIV_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control side
  shift_if.eng sif,
  // Serial pins
  input wire logic misoSync,
  output logic sckOut,
  output logic mosiOut
);
  typedef struct packed {
    xfer_state_t st;
    logic [15:0] sh;
    logic [4:0] bits;
    logic [7:0] div;
    logic sck;
    logic done;
    logic started;
    logic rxBit;
  } eng_t;
  eng_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.started = 1'b0;
    unique case (s_r.st)
      IDLE: begin
        if (sif.start && !sif.abort) begin
          s_nxt.st = SHIFT;
          s_nxt.sh = sif.wide ? sif.txWord : {sif.txWord[7:0], 8'h00};
          s_nxt.bits = sif.wide ? 5'd16 : 5'd8;
          s_nxt.div = 8'h00;
          s_nxt.sck = 1'b0;
          s_nxt.started = 1'b1;
        end
      end
      SHIFT: begin
        if (sif.abort) begin
          s_nxt.st = IDLE;
          s_nxt.sck = 1'b0;
        end else if (s_r.div == 8'(DIV - 1)) begin
          s_nxt.div = 8'h00;
          s_nxt.sck = !s_r.sck;
          if (s_r.sck) begin
            s_nxt.sh = {s_r.sh[14:0], s_r.rxBit};
            s_nxt.bits = s_r.bits - 5'd1;
            if (s_r.bits == 5'd1) begin
              s_nxt.st = IDLE;
              s_nxt.done = 1'b1;
            end
          end else begin
            s_nxt.rxBit = misoSync;
          end
        end else begin
          s_nxt.div = s_r.div + 8'h01;
        end
      end
      default: s_nxt.st = IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Sampled bit waits until the falling edge, so the last transmit bit is never overwritten
  assign sif.rxWord = sif.wide ? s_r.sh : {8'h00, s_r.sh[7:0]};
  assign sif.busy = (s_r.st == SHIFT);
  assign sif.done = s_r.done;
  assign sif.started = s_r.started;
  assign sckOut = s_r.sck;
  assign mosiOut = s_r.sh[15];
endmodule

// ---- rtl/spi_status_buf.sv ----
// Status flags and data buffering of the serial peripheral, Avalon-MM slave.
// Assumes word addressing: address n is register byte n in data bits 7:0.
module spi_status_buf
  import spi_buf_pkg::*;
#(
  parameter int DIV = DIV_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // Serial pins
  input wire logic slaveSelN,
  input wire logic misoIn,
  output logic sckOut,
  output logic sckOe,
  output logic mosiOut,
  output logic mosiOe,
  // Interrupt request
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrlOne;
    logic [7:0] ctrlTwo;
    logic rxFlag;
    logic txEmpty;
    logic faultFlag;
    logic rxArmed;
    logic txArmed;
    logic faultArmed;
    logic [15:0] rxData;
    logic [15:0] txData;
    logic [15:0] pendData;
    logic pendValid;
    logic pendStale;
    logic txQueued;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [1:0] ssSync;
    logic [1:0] misoSyncR;
  } top_t;
  top_t s_r, s_nxt;

  shift_if sif ();

  logic isMaster, wide, faultEn, rdHit, wrHit, faultEvent;

  assign isMaster = s_r.ctrlOne[MASTER_BIT];
  assign wide = s_r.ctrlTwo[WIDTH_BIT];
  assign faultEn = s_r.ctrlTwo[FAULT_EN_BIT];
  assign rdHit = read && !s_r.ack;
  assign wrHit = write && !s_r.ack;
  assign faultEvent = isMaster && faultEn && !s_r.ssSync[1];

  always_comb begin
    s_nxt = s_r;
    s_nxt.ssSync = {s_r.ssSync[0], slaveSelN};
    s_nxt.misoSyncR = {s_r.misoSyncR[0], misoIn};
    s_nxt.ack = (read || write) && !s_r.ack;
    s_nxt.resp = 2'b00;
    s_nxt.rdata = 32'h0000_0000;
    // Register access, one wait state
    if (rdHit) begin
      unique case (address)
        CTRL_ONE_OFS: s_nxt.rdata[7:0] = s_r.ctrlOne;
        CTRL_TWO_OFS: s_nxt.rdata[7:0] = s_r.ctrlTwo;
        STATUS_OFS: begin
          s_nxt.rdata[RX_FLAG_BIT] = s_r.rxFlag;
          s_nxt.rdata[TX_EMPTY_BIT] = s_r.txEmpty;
          s_nxt.rdata[FAULT_BIT] = s_r.faultFlag;
          s_nxt.rxArmed = s_r.rxFlag;
          s_nxt.txArmed = s_r.txEmpty;
          s_nxt.faultArmed = s_r.faultFlag;
        end
        DATA_HIGH_OFS: s_nxt.rdata[7:0] = s_r.rxData[15:8];
        DATA_LOW_OFS: begin
          s_nxt.rdata[7:0] = s_r.rxData[7:0];
          if (s_r.rxArmed && s_r.rxFlag) begin
            s_nxt.rxFlag = 1'b0;
            s_nxt.rxArmed = 1'b0;
            if (wide) begin
              s_nxt.rxData[15:8] = DATA_RESET;
            end
          end
        end
        default: s_nxt.resp = 2'b10;
      endcase
    end
    if (wrHit && byteenable[0]) begin
      unique case (address)
        CTRL_ONE_OFS: begin
          s_nxt.ctrlOne = writedata[7:0];
          if (s_r.faultArmed && s_r.faultFlag) begin
            s_nxt.faultFlag = 1'b0;
            s_nxt.faultArmed = 1'b0;
          end
        end
        CTRL_TWO_OFS: s_nxt.ctrlTwo = writedata[7:0];
        STATUS_OFS: ;
        DATA_HIGH_OFS: begin
          if (s_r.txEmpty) begin
            s_nxt.txData[15:8] = writedata[7:0];
          end
        end
        DATA_LOW_OFS: begin
          if (s_r.txEmpty) begin
            s_nxt.txData[7:0] = writedata[7:0];
            if (s_r.txArmed) begin
              s_nxt.txEmpty = 1'b0;
              s_nxt.txArmed = 1'b0;
              s_nxt.txQueued = 1'b1;
            end
          end
        end
        default: s_nxt.resp = 2'b10;
      endcase
    end else if (wrHit && address > DATA_LOW_OFS) begin
      s_nxt.resp = 2'b10;
    end
    // Queue hand-off: the buffer empties as the engine takes the word
    if (sif.started) begin
      s_nxt.txQueued = 1'b0;
      s_nxt.txEmpty = 1'b1;
      if (s_r.pendValid) begin
        s_nxt.pendStale = 1'b1;
      end
    end
    // Receive path
    if (sif.done) begin
      if (!s_nxt.rxFlag) begin
        s_nxt.rxData = sif.rxWord;
        s_nxt.rxFlag = 1'b1;
      end else begin
        s_nxt.pendData = sif.rxWord;
        s_nxt.pendValid = 1'b1;
        s_nxt.pendStale = 1'b0;
      end
    end else if (s_r.pendValid && !s_r.rxFlag) begin
      if (!s_r.pendStale) begin
        s_nxt.rxData = s_r.pendData;
        s_nxt.rxFlag = 1'b1;
      end
      s_nxt.pendValid = 1'b0;
      s_nxt.pendStale = 1'b0;
    end
    // Mode fault wins over a same-cycle clear
    if (faultEvent) begin
      s_nxt.faultFlag = 1'b1;
      s_nxt.ctrlOne[MASTER_BIT] = 1'b0;
      s_nxt.txQueued = 1'b0;
      s_nxt.txEmpty = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctrlOne <= CTRL_ONE_RESET;
      s_r.ctrlTwo <= CTRL_TWO_RESET;
      s_r.txEmpty <= 1'b1;
      s_r.ssSync <= 2'b11;
      s_r.rxData <= {DATA_RESET, DATA_RESET};
      s_r.txData <= {DATA_RESET, DATA_RESET};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Queued word leaves as soon as the engine is idle while in master mode
  assign sif.start = s_r.txQueued && isMaster && !sif.busy;
  assign sif.abort = faultEvent || !isMaster;
  assign sif.wide = wide;
  assign sif.txWord = s_r.txData;

  spi_shift_engine #(
    .DIV(DIV)
  ) engine (
    .core_clk(core_clk),
    .reset(reset),
    .sif(sif),
    .misoSync(s_r.misoSyncR[1]),
    .sckOut(sckOut),
    .mosiOut(mosiOut)
  );

  assign sckOe = isMaster;
  assign mosiOe = isMaster;
  assign irq = s_r.faultFlag && s_r.ctrlOne[IRQ_EN_BIT];
  assign waitrequest = (read || write) && !s_r.ack;
  assign readdata = s_r.rdata;
  assign response = s_r.resp;
endmodule

// ---- sim/spi_slave_model.sv ----
// Far-side serial device: mode 0, msb first, replies from a loaded word.
// Assumes sck rests low and sel is high only while the master drives.
module spi_slave_model (
  // Serial pins
  input wire logic sck,
  input wire logic sel,
  input wire logic mosi,
  output logic miso,
  // Bench side
  input wire logic load,
  input wire logic [15:0] reply,
  output logic [15:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh = 16'h0;
  always @(posedge load) sh = reply;
  always @(posedge sck) got = {got[14:0], mosi};
  always @(negedge sck) sh = {sh[14:0], 1'b0};
  // Released line shows the inverse so a stale sample cannot pass
  always_comb miso = sel ? sh[15] : !sh[15];
endmodule

// ---- sim/spi_status_buf_sva.sv ----
// Port checker for the status and data buffer block.
// Assumes one wait state per access and word addressing.
module spi_status_buf_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Bus
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // Pins
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic mosiOut,
  input wire logic mosiOe,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic done = (read | write) & !waitrequest;
  wire logic bad = address inside {3'h2, 3'h6, 3'h7};
  chk_one_wait: assert property ((read | write) && waitrequest |=> !waitrequest)
    else $error("no answer after one wait state");
  chk_idle_nowait: assert property (!(read | write) |-> !waitrequest)
    else $error("wait raised with no request");
  chk_rsvd_zero: assert property (done && read && address == 3'h3
    |-> readdata[6] == 1'b0 && readdata[3:0] == 4'h0) else $error("reserved status bit set");
  chk_upper_zero: assert property (done && read |-> readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_unmapped_err: assert property (done && bad |-> response == 2'b10)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (done && !bad |-> response == 2'b00)
    else $error("mapped access refused");
  chk_oe_pair: assert property (sckOe == mosiOe)
    else $error("output enables differ");
  // Three quiet cycles allow for the abort to land after the mode change
  chk_slave_quiet: assert property (!sckOe && !$past(sckOe) && !$past(sckOe, 3)
    |-> $stable(sckOut) && $stable(mosiOut)) else $error("pins move while not master");
  cover property (done && read && address == 3'h3);
  cover property ($rose(irq));
  cover property ($fell(sckOe));
endmodule
bind spi_status_buf spi_status_buf_sva chk_u (.core_clk, .reset, .address, .read, .write,
  .readdata, .waitrequest, .response, .sckOut, .sckOe, .mosiOut, .mosiOe, .irq);

// ---- sim/testbench.sv ----
// Self-checking bench for the status and data buffer block.
// Assumes mode 0 msb first, one wait state, ctrl one at 0 and ctrl two at 1.
module testbench
  import spi_buf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, reset = 1, read = 0, write = 0, slaveSelN = 1, load = 0;
  logic [2:0] address = 0;
  logic [31:0] writedata = 0, readdata, rng = 32'h7e128855;
  logic [1:0] response, rsp;
  logic waitrequest, misoIn, sckOut, sckOe, mosiOut, mosiOe, irq;
  logic [15:0] reply = 0, got;
  logic [7:0] q, hi;
  logic [7:0] expQ[$];
  int numErrors = 0, nCompared = 0;
  initial forever #5 core_clk = ~core_clk;
  spi_status_buf #(.DIV(4)) dut_u (.core_clk, .reset, .address, .read, .write, .writedata,
    .byteenable(4'hf), .readdata, .waitrequest, .response, .slaveSelN, .misoIn, .sckOut,
    .sckOe, .mosiOut, .mosiOe, .irq);
  spi_slave_model peer_u (.sck(sckOut), .sel(sckOe), .mosi(mosiOut), .miso(misoIn), .load,
    .reply, .got);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic reportAndStop();
    $display("errors %0d compares %0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      numErrors++;
      reportAndStop();
    end
    q = readdata[7:0];
    rsp = response;
    read <= 0;
    write <= 0;
    @(posedge core_clk);
  endtask
  task automatic newReply();
    rng = xs(rng);
    reply <= rng[15:0];
    load <= 1;
    @(posedge core_clk);
    load <= 0;
  endtask
  task automatic waitRx();
    int n;
    n = 0;
    do begin
      bus(0, STATUS_OFS, 8'h0);
      n++;
    end while (q[RX_FLAG_BIT] !== 1'b1 && n < 200);
    check("rx flag", 1, q[RX_FLAG_BIT]);
    if (q[RX_FLAG_BIT] !== 1'b1) reportAndStop();
  endtask
  task automatic waitTx();
    int n;
    n = 0;
    do begin
      bus(0, STATUS_OFS, 8'h0);
      n++;
    end while (q[TX_EMPTY_BIT] !== 1'b1 && n < 200);
    check("tx taken", 1, q[TX_EMPTY_BIT]);
    if (q[TX_EMPTY_BIT] !== 1'b1) reportAndStop();
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 0;
    bus(0, STATUS_OFS, 8'h0);
    check("status reset", 8'h20, q);
    bus(1, STATUS_OFS, 8'hff);
    bus(0, STATUS_OFS, 8'h0);
    check("status write", 8'h20, q);
    bus(0, DATA_HIGH_OFS, 8'h0);
    check("high reset", 0, q);
    bus(0, 3'h6, 8'h0);
    check("unmapped", 2'b10, rsp);
    bus(1, CTRL_ONE_OFS, 8'h10);
    for (int i = 0; i < 4; i++) begin
      newReply();
      expQ.push_back(reply[15:8]);
      bus(0, STATUS_OFS, 8'h0);
      bus(1, DATA_LOW_OFS, rng[23:16]);
      waitRx();
      bus(0, DATA_LOW_OFS, 8'h0);
      check("rx byte", expQ.pop_front(), q);
      check("tx byte", rng[23:16], got[7:0]);
      bus(0, STATUS_OFS, 8'h0);
      check("rx cleared", 8'h20, q);
    end
    // Two queued bytes, a refused third, and an unserviced second reception
    newReply();
    expQ = {reply[15:8], reply[7:0]};
    bus(0, STATUS_OFS, 8'h0);
    bus(1, DATA_LOW_OFS, rng[23:16]);
    bus(0, STATUS_OFS, 8'h0);
    bus(1, DATA_LOW_OFS, rng[31:24]);
    bus(0, STATUS_OFS, 8'h0);
    check("tx full", 0, q[TX_EMPTY_BIT]);
    bus(1, DATA_LOW_OFS, 8'h5a);
    repeat (300) @(posedge core_clk);
    check("two sent", {rng[23:16], rng[31:24]}, got);
    bus(0, STATUS_OFS, 8'h0);
    bus(0, DATA_LOW_OFS, 8'h0);
    check("first held", expQ.pop_front(), q);
    bus(0, STATUS_OFS, 8'h0);
    check("flag kept", 1, q[RX_FLAG_BIT]);
    bus(0, DATA_LOW_OFS, 8'h0);
    check("second moved", expQ.pop_front(), q);
    // Third start while a second value waits: the waiting value is lost
    newReply();
    expQ = {reply[15:8], 8'h00};
    bus(0, STATUS_OFS, 8'h0);
    bus(1, DATA_LOW_OFS, rng[23:16]);
    bus(0, STATUS_OFS, 8'h0);
    bus(1, DATA_LOW_OFS, rng[31:24]);
    waitTx();
    bus(1, DATA_LOW_OFS, 8'h3c);
    waitTx();
    bus(0, DATA_LOW_OFS, 8'h0);
    check("late first", expQ.pop_front(), q);
    bus(0, STATUS_OFS, 8'h0);
    check("late dropped", 8'h20, q);
    waitRx();
    bus(0, DATA_LOW_OFS, 8'h0);
    check("third byte", expQ.pop_front(), q);
    // Sixteen-bit word, high byte written and read alone first
    bus(1, CTRL_TWO_OFS, 8'h40);
    newReply();
    bus(0, STATUS_OFS, 8'h0);
    bus(1, DATA_HIGH_OFS, rng[23:16]);
    bus(0, STATUS_OFS, 8'h0);
    check("high only", 1, q[TX_EMPTY_BIT]);
    bus(1, DATA_LOW_OFS, rng[31:24]);
    waitRx();
    bus(0, DATA_HIGH_OFS, 8'h0);
    bus(0, DATA_HIGH_OFS, 8'h0);
    hi = q;
    bus(0, STATUS_OFS, 8'h0);
    check("high read", 1, q[RX_FLAG_BIT]);
    bus(0, DATA_LOW_OFS, 8'h0);
    check("rx word", reply, {hi, q});
    check("tx word", {rng[23:16], rng[31:24]}, got);
    bus(0, DATA_HIGH_OFS, 8'h0);
    check("high dropped", 0, q);
    // Mode fault while master with interrupt enabled
    bus(1, CTRL_TWO_OFS, 8'h10);
    bus(1, CTRL_ONE_OFS, 8'h90);
    slaveSelN <= 0;
    repeat (8) @(posedge core_clk);
    bus(0, STATUS_OFS, 8'h0);
    check("fault flag", 8'h30, q);
    check("fault irq", 1, irq);
    check("fault oe", 0, sckOe);
    slaveSelN <= 1;
    bus(1, CTRL_ONE_OFS, 8'h80);
    bus(0, STATUS_OFS, 8'h0);
    check("fault clear", 8'h20, q);
    check("irq clear", 0, irq);
    reportAndStop();
  end
endmodule
